// ===== rut_edge_sync.sv
// Two-flop synchroniser with rising and falling edge pulses.
// Assumes async_in may change at any time relative to pclk.
module rut_edge_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic rise,
	output logic fall
);

	logic [2:0] sync_reg;
	logic [2:0] sync_next;

	always_comb begin
		sync_next = {sync_reg[1:0], async_in};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_reg <= 3'h0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	// Edges seen between second and third stage only
	assign rise = sync_reg[1] & ~sync_reg[2];
	assign fall = ~sync_reg[1] & sync_reg[2];

endmodule

// ===== rut_far_end.sv
// Far-side model: event pin, direction pin and watch clock tap.
// Assumes the bench calls its tasks right after a pclk rising edge.
module rut_far_end (
	input wire logic pclk,
	output logic event_input_pin,
	output logic direction_pin,
	output logic watch_clk_div4
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		event_input_pin = 1'b0;
		direction_pin = 1'b0;
		watch_clk_div4 = 1'b0;
	end

	// Pulses stay 4 cycles high and low for the synchroniser
	task automatic pulse_event(input int n);
		repeat (n) begin
			event_input_pin <= 1'b1;
			repeat (4) @(posedge pclk);
			event_input_pin <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask

	task automatic watch_ticks(input int n);
		repeat (n) begin
			watch_clk_div4 <= 1'b1;
			repeat (4) @(posedge pclk);
			watch_clk_div4 <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask

	task automatic set_dir(input logic v);
		direction_pin <= v;
		@(posedge pclk);
	endtask
endmodule

// ===== rut_pkg.sv
// Constants shared by the reloadable up/down timer and its helpers.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package rut_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [15:0] IDX_MODE = 16'hffb4;
	localparam logic [15:0] IDX_COUNT = 16'hffb5;
	localparam logic [15:0] IDX_GATE = 16'hfffa;
	localparam logic [15:0] IDX_AUX = 16'hffb3;
	localparam logic [13:0] ADDR_HIGH_ZERO = 14'h0000;
	localparam logic [1:0] ADDR_WORD_ZERO = 2'h0;

	// ------------------------------------------------------------
	// Mode register fields
	// ------------------------------------------------------------
	localparam logic [7:0] MODE_RESET = 8'h18;
	localparam logic [7:0] MODE_FIXED_MASK = 8'h18;
	localparam int MODE_AUTO_BIT = 7;
	localparam int MODE_HWDIR_BIT = 6;
	localparam int MODE_DOWN_BIT = 5;
	localparam int MODE_CSEL_MSB = 2;
	localparam int MODE_CSEL_LSB = 0;

	// Clock select codes
	localparam logic [2:0] CSEL_DIV8192 = 3'h0;
	localparam logic [2:0] CSEL_DIV2048 = 3'h1;
	localparam logic [2:0] CSEL_DIV512 = 3'h2;
	localparam logic [2:0] CSEL_DIV64 = 3'h3;
	localparam logic [2:0] CSEL_DIV16 = 3'h4;
	localparam logic [2:0] CSEL_DIV4 = 3'h5;
	localparam logic [2:0] CSEL_WATCH = 3'h6;
	localparam logic [2:0] CSEL_EVENT = 3'h7;

	// ------------------------------------------------------------
	// Prescaler: number of taps and width of each tap's divider
	// ------------------------------------------------------------
	localparam int PRE_TAPS = 6;
	localparam int PRE_BITS = 13;
	localparam int PRE_WIDTH [0:PRE_TAPS-1] = '{13, 11, 9, 6, 4, 2};
	localparam logic [PRE_BITS-1:0] PRE_RESET = 13'h0000;
	localparam logic [PRE_BITS-1:0] PRE_STEP = 13'h0001;

	// ------------------------------------------------------------
	// Counter, clock gate and auxiliary register
	// ------------------------------------------------------------
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_MIN = 8'h00;
	localparam logic [7:0] COUNT_STEP = 8'h01;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] GATE_RESET = 8'hff;
	localparam int GATE_STANDBY_BIT = 1;
	localparam logic [7:0] AUX_RESET = 8'h00;
	localparam int AUX_FLAG_BIT = 0;
	localparam int AUX_IRQ_EN_BIT = 1;
	localparam int AUX_EDGE_BIT = 2;
	localparam int AUX_PINFN_BIT = 3;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
	localparam logic [23:0] RDATA_PAD = 24'h00_0000;

endpackage

// ===== rut_prescaler.sv
// Free-running system clock divider giving one-cycle taps.
// Assumes pclk is the system clock; taps run even in standby.
module rut_prescaler (
	input wire logic pclk,
	input wire logic presetn,
	output logic [rut_pkg::PRE_TAPS-1:0] tick
);

	logic [rut_pkg::PRE_BITS-1:0] div_reg;
	logic [rut_pkg::PRE_BITS-1:0] div_next;

	always_comb begin
		div_next = div_reg + rut_pkg::PRE_STEP;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= rut_pkg::PRE_RESET;
		end else begin
			div_reg <= div_next;
		end
	end

	// A tap pulses once every 2**width cycles
	genvar i;
	generate
		for (i = 0; i < rut_pkg::PRE_TAPS; i++) begin : g_tap
			assign tick[i] = &div_reg[rut_pkg::PRE_WIDTH[i]-1:0];
		end
	endgenerate

endmodule

// ===== rut_timer.sv
// 8-bit reloadable up/down timer with APB register access.
// Assumes APB master on pclk; pins synchronous or synchronised here.
//
// Notes on behaviour
// - 8-bit counter steps by one per active pulse of the count clock.
// - Mode bit 7 picks interval (0, reset) or auto-reload (1).
// - With bit 6 low, bit 5 picks up (0, reset) or down (1).
// - With bit 6 high, direction pin high counts down, low counts up.
// - Mode bits 4 and 3 always read 1; writes ignored.
// - Clock select picks system /8192 down to /4, or watch clock /4.
// - Code 111 counts event pin edges; edge chosen by edge-select bit.
// - Mode register resets to 0x18.
// - Counter readable anytime without disturbing it; not writable directly.
// - Flag sets when counter wraps up from 0xFF or down from 0x00.
// - Counter and load register share one address: read counter, write load.
// - Load write also sets counter at once; counting continues from it.
// - Auto-reload mode loads the load value on every wrap.
// - Counter and load register reset to 0x00.
// - Clock-gate bit 1 puts the timer in or out of standby.
// - In low-speed mode only watch or event sources keep counting.
// - Standby bit 0 halts, 1 runs; resets to 1.
// - Interrupt requested when flag is set and its enable is 1.
module rut_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic event_input_pin,
	input wire logic direction_pin,
	input wire logic watch_clk_div4,
	input wire logic low_speed_mode,
	output logic overflow_request_flag,
	output logic timer_irq_req
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [31:0] a,
		input logic [15:0] idx);
		reg_hit = (a == {rut_pkg::ADDR_HIGH_ZERO, idx,
			rut_pkg::ADDR_WORD_ZERO});
	endfunction

	logic hit_mode;
	logic hit_count;
	logic hit_gate;
	logic hit_aux;
	logic hit_any;
	logic wr_access;
	logic setup_phase;
	logic wr_mode;
	logic wr_count;
	logic wr_gate;
	logic wr_aux;

	assign hit_mode = reg_hit(paddr, rut_pkg::IDX_MODE);
	assign hit_count = reg_hit(paddr, rut_pkg::IDX_COUNT);
	assign hit_gate = reg_hit(paddr, rut_pkg::IDX_GATE);
	assign hit_aux = reg_hit(paddr, rut_pkg::IDX_AUX);
	assign hit_any = hit_mode | hit_count | hit_gate | hit_aux;
	assign setup_phase = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign wr_mode = wr_access & hit_mode;
	assign wr_count = wr_access & hit_count;
	assign wr_gate = wr_access & hit_gate;
	assign wr_aux = wr_access & hit_aux;

	// Zero wait states
	assign pready = 1'b1;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	logic [7:0] mode_reg;
	logic [7:0] mode_next;
	logic [7:0] gate_reg;
	logic [7:0] gate_next;
	logic [7:0] aux_reg;
	logic [7:0] aux_next;
	logic wrap;

	always_comb begin
		mode_next = mode_reg;
		gate_next = gate_reg;
		aux_next = aux_reg;
		if (wr_mode) begin
			// Fixed bits forced high
			mode_next = (pwdata[7:0] & ~rut_pkg::MODE_FIXED_MASK)
				| rut_pkg::MODE_FIXED_MASK;
		end
		if (wr_gate) begin
			gate_next = pwdata[7:0];
		end
		if (wr_aux) begin
			// Flag clears by writing 0, writing 1 keeps it
			aux_next = {pwdata[7:1],
				pwdata[rut_pkg::AUX_FLAG_BIT]
				& aux_reg[rut_pkg::AUX_FLAG_BIT]};
		end
		if (wrap) begin
			// Set wins over a clear in the same cycle
			aux_next[rut_pkg::AUX_FLAG_BIT] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= rut_pkg::MODE_RESET;
			gate_reg <= rut_pkg::GATE_RESET;
			aux_reg <= rut_pkg::AUX_RESET;
		end else begin
			mode_reg <= mode_next;
			gate_reg <= gate_next;
			aux_reg <= aux_next;
		end
	end

	logic auto_reload_select;
	logic hw_direction_enable;
	logic sw_count_down;
	logic [2:0] clock_select;
	logic module_standby_ctrl;
	logic overflow_irq_enable;
	logic event_edge_select;
	logic event_pin_function_enable;

	assign auto_reload_select = mode_reg[rut_pkg::MODE_AUTO_BIT];
	assign hw_direction_enable = mode_reg[rut_pkg::MODE_HWDIR_BIT];
	assign sw_count_down = mode_reg[rut_pkg::MODE_DOWN_BIT];
	assign clock_select =
		mode_reg[rut_pkg::MODE_CSEL_MSB:rut_pkg::MODE_CSEL_LSB];
	assign module_standby_ctrl = gate_reg[rut_pkg::GATE_STANDBY_BIT];
	assign overflow_irq_enable = aux_reg[rut_pkg::AUX_IRQ_EN_BIT];
	assign event_edge_select = aux_reg[rut_pkg::AUX_EDGE_BIT];
	assign event_pin_function_enable = aux_reg[rut_pkg::AUX_PINFN_BIT];
	assign overflow_request_flag = aux_reg[rut_pkg::AUX_FLAG_BIT];
	assign timer_irq_req = overflow_request_flag
		& overflow_irq_enable;

	// ------------------------------------------------------------
	// Count clock sources
	// ------------------------------------------------------------
	logic [rut_pkg::PRE_TAPS-1:0] pre_tick;
	logic watch_rise;
	logic event_rise;
	logic event_fall;

	rut_prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.tick(pre_tick)
	);

	rut_edge_sync u_watch_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(watch_clk_div4),
		.rise(watch_rise),
		.fall()
	);

	rut_edge_sync u_event_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(event_input_pin),
		.rise(event_rise),
		.fall(event_fall)
	);

	logic src_tick;
	logic low_speed_ok;
	logic count_en;
	logic count_down;

	always_comb begin
		case (clock_select)
			rut_pkg::CSEL_DIV8192: src_tick = pre_tick[0];
			rut_pkg::CSEL_DIV2048: src_tick = pre_tick[1];
			rut_pkg::CSEL_DIV512: src_tick = pre_tick[2];
			rut_pkg::CSEL_DIV64: src_tick = pre_tick[3];
			rut_pkg::CSEL_DIV16: src_tick = pre_tick[4];
			rut_pkg::CSEL_DIV4: src_tick = pre_tick[5];
			rut_pkg::CSEL_WATCH: src_tick = watch_rise;
			rut_pkg::CSEL_EVENT: begin
				// Edges count only once the pin function is on
				src_tick = event_pin_function_enable
					& (event_edge_select ? event_rise
					: event_fall);
			end
			default: src_tick = 1'b0;
		endcase
	end

	assign low_speed_ok = ~low_speed_mode
		| (clock_select == rut_pkg::CSEL_WATCH)
		| (clock_select == rut_pkg::CSEL_EVENT);
	assign count_en = src_tick & module_standby_ctrl
		& low_speed_ok;
	assign count_down = hw_direction_enable ? direction_pin
		: sw_count_down;

	// ------------------------------------------------------------
	// Counter and load register
	// ------------------------------------------------------------
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic [7:0] reload_reg;
	logic [7:0] reload_next;

	assign wrap = count_en & ~wr_count
		& (count_down ? (count_reg == rut_pkg::COUNT_MIN)
		: (count_reg == rut_pkg::COUNT_MAX));

	always_comb begin
		count_next = count_reg;
		reload_next = reload_reg;
		if (wr_count) begin
			// Write beats a count in the same cycle
			reload_next = pwdata[7:0];
			count_next = pwdata[7:0];
		end else if (wrap && auto_reload_select) begin
			count_next = reload_reg;
		end else if (count_en) begin
			count_next = count_down
				? count_reg - rut_pkg::COUNT_STEP
				: count_reg + rut_pkg::COUNT_STEP;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= rut_pkg::COUNT_RESET;
			reload_reg <= rut_pkg::RELOAD_RESET;
		end else begin
			count_reg <= count_next;
			reload_reg <= reload_next;
		end
	end

	// ------------------------------------------------------------
	// Read data, captured in the setup cycle
	// ------------------------------------------------------------
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pslverr_reg;
	logic pslverr_next;

	always_comb begin
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		if (setup_phase) begin
			pslverr_next = ~hit_any;
			if (pwrite || !hit_any) begin
				prdata_next = rut_pkg::RDATA_ZERO;
			end else if (hit_mode) begin
				prdata_next = {rut_pkg::RDATA_PAD, mode_reg};
			end else if (hit_count) begin
				// Read never touches the counter
				prdata_next = {rut_pkg::RDATA_PAD,
					count_reg};
			end else if (hit_gate) begin
				prdata_next = {rut_pkg::RDATA_PAD, gate_reg};
			end else begin
				prdata_next = {rut_pkg::RDATA_PAD, aux_reg};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= rut_pkg::RDATA_ZERO;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg & psel & penable;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_reserved_ones: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode_reg[4:3] == 2'b11)
		else $error("mode reserved bits not one");

	a_load_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_count |=> (count_reg == $past(pwdata[7:0]))
		&& (reload_reg == $past(pwdata[7:0])))
		else $error("load write did not reach counter");

	a_wrap_flag: assert property (
		@(posedge pclk) disable iff (!presetn)
		count_en && !wr_count && !count_down
		&& count_reg == 8'hff |=> overflow_request_flag)
		else $error("overflow flag not set on wrap");

	a_auto_reload: assert property (
		@(posedge pclk) disable iff (!presetn)
		wrap && auto_reload_select
		|=> count_reg == $past(reload_reg))
		else $error("auto reload value not loaded");

	a_interval_wrap: assert property (
		@(posedge pclk) disable iff (!presetn)
		wrap && !auto_reload_select && !count_down
		|=> count_reg == 8'h00)
		else $error("interval wrap not to zero");

	a_standby_halt: assert property (
		@(posedge pclk) disable iff (!presetn)
		!module_standby_ctrl && !wr_count |=> $stable(count_reg))
		else $error("counter moved in standby");

	a_low_speed: assert property (
		@(posedge pclk) disable iff (!presetn)
		low_speed_mode && clock_select < 3'h6 && !wr_count
		|=> $stable(count_reg))
		else $error("counter moved on fast source in low speed");

	a_hw_down: assert property (
		@(posedge pclk) disable iff (!presetn)
		count_en && hw_direction_enable && direction_pin
		&& !wr_count && count_reg != 8'h00
		|=> count_reg == $past(count_reg) - 8'h01)
		else $error("pin high did not count down");

	a_sw_up: assert property (
		@(posedge pclk) disable iff (!presetn)
		count_en && !hw_direction_enable && !sw_count_down
		&& !wr_count && count_reg != 8'hff
		|=> count_reg == $past(count_reg) + 8'h01)
		else $error("software up count wrong");

	a_irq_pair: assert property (
		@(posedge pclk) disable iff (!presetn)
		wrap && overflow_irq_enable && !wr_aux
		|=> timer_irq_req)
		else $error("interrupt not requested");

endmodule

// ===== test_reloadable_updown_timer8.sv
// Self-checking bench for the up/down timer over APB.
// Assumes zero-wait APB slave and the far-side model beside it.
module test_reloadable_updown_timer8;
	timeunit 1ns;
	timeprecision 1ns;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic event_input_pin, direction_pin, watch_clk_div4, low_speed_mode;
	logic overflow_request_flag, timer_irq_req, err_val;
	logic [7:0] rd_val;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	localparam logic [15:0] M = rut_pkg::IDX_MODE;
	localparam logic [15:0] C = rut_pkg::IDX_COUNT;
	localparam logic [15:0] G = rut_pkg::IDX_GATE;
	localparam logic [15:0] X = rut_pkg::IDX_AUX;

	rut_timer dut_u (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.event_input_pin(event_input_pin),
		.direction_pin(direction_pin),
		.watch_clk_div4(watch_clk_div4),
		.low_speed_mode(low_speed_mode),
		.overflow_request_flag(overflow_request_flag),
		.timer_irq_req(timer_irq_req)
	);
	rut_far_end far_u (
		.pclk(pclk),
		.event_input_pin(event_input_pin),
		.direction_pin(direction_pin),
		.watch_clk_div4(watch_clk_div4)
	);

	// ------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [15:0] idx,
		input logic [7:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {rut_pkg::ADDR_HIGH_ZERO, idx, rut_pkg::ADDR_WORD_ZERO};
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for pready from the slave; the bench timeout ends this if it never comes
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_val = prdata[7:0];
		err_val = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rdc(input logic [15:0] idx, input logic [7:0] exp,
		input string name);
		apb(1'b0, idx, 8'h00);
		check(name, exp, rd_val);
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		low_speed_mode = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(M, 8'h18, "mode reset");
		check("mapped error", 8'h00, {7'h00, err_val});
		rdc(C, 8'h00, "count reset");
		rdc(G, 8'hff, "gate reset");
		rdc(X, 8'h00, "aux reset");
		for (int c = 0; c < 7; c++) begin
			wr(M, 8'(c));
			rdc(M, 8'h18 | 8'(c), "mode field");
		end
		apb(1'b0, 16'h0000, 8'h00);
		check("unmapped error", 8'h01, {7'h00, err_val});
		check("unmapped data", 8'h00, rd_val);
		// Event counting, interval up, wrap
		wr(X, 8'h0c);
		wr(M, 8'h07);
		wr(C, 8'hfe);
		rdc(C, 8'hfe, "load to count");
		rdc(C, 8'hfe, "read stable");
		far_u.pulse_event(2);
		rdc(C, 8'h00, "up wrap");
		rdc(X, 8'h0d, "flag up");
		check("irq masked", 8'h00, {7'h00, timer_irq_req});
		wr(X, 8'h0f);
		check("irq raised", 8'h01, {7'h00, timer_irq_req});
		wr(X, 8'h0c);
		check("flag clear", 8'h00, {7'h00, overflow_request_flag});
		// Software down count, underflow
		wr(M, 8'h27);
		wr(C, 8'h01);
		far_u.pulse_event(2);
		rdc(C, 8'hff, "down wrap");
		rdc(X, 8'h0d, "flag down");
		wr(X, 8'h0c);
		// Auto-reload
		wr(M, 8'h87);
		wr(C, 8'hfe);
		wr(X, 8'h0e);
		far_u.pulse_event(2);
		rdc(C, 8'hfe, "reload wrap");
		rdc(X, 8'h0f, "flag reload");
		check("irq reload", 8'h01, {7'h00, timer_irq_req});
		wr(X, 8'h0c);
		// Pin direction, bit 5 ignored
		far_u.set_dir(1'b1);
		wr(M, 8'hc7);
		wr(C, 8'h10);
		far_u.pulse_event(1);
		rdc(C, 8'h0f, "pin down");
		far_u.set_dir(1'b0);
		wr(M, 8'he7);
		far_u.pulse_event(1);
		rdc(C, 8'h10, "pin up");
		// Module standby
		wr(G, 8'hfd);
		rdc(G, 8'hfd, "gate write");
		far_u.pulse_event(2);
		rdc(C, 8'h10, "standby halt");
		wr(C, 8'h40);
		wr(G, 8'hff);
		far_u.pulse_event(1);
		rdc(C, 8'h41, "standby release");
		// Falling edge selection
		wr(X, 8'h08);
		wr(M, 8'h07);
		wr(C, 8'h30);
		far_u.pulse_event(1);
		rdc(C, 8'h31, "falling edge");
		// Pin function off: edges must be ignored
		wr(X, 8'h04);
		far_u.pulse_event(1);
		rdc(C, 8'h31, "pin function off");
		// Low-speed mode: only watch or event sources
		wr(M, 8'h05);
		// Low speed before the load, so no /4 tick slips in
		low_speed_mode <= 1'b1;
		wr(C, 8'h20);
		repeat (40) @(posedge pclk);
		rdc(C, 8'h20, "low speed halt");
		wr(M, 8'h06);
		far_u.watch_ticks(3);
		rdc(C, 8'h23, "watch count");
		low_speed_mode <= 1'b0;
		wr(M, 8'h05);
		wr(C, 8'h00);
		repeat (40) @(posedge pclk);
		apb(1'b0, C, 8'h00);
		check("div4 rate", 8'h01,
			{7'h00, rd_val >= 8 && rd_val <= 12});
		print_verdict();
	end
endmodule
